//--- bcs_consts.svh
// Purpose: Constants for the block copy sequencer
// Assumes: One clock MCLK at 125 MHz, one state per clock
// Notes:   Function list follows
// Function
// [R1] Byte form copies one byte source to destination, both pointers plus one.
// [R2] Word form uses full 16-bit count, minus one per byte, stops at zero.
// [R3] Zero count is tested first; no memory access, instruction just ends.
// [R4] On-chip memory timing is 8 states plus 4 states per byte.
// [R5] Byte form lowers the low count byte per byte until it is zero.
// [R6] Strobe-synchronised transfers take a variable number of states.
// [R7] Done only after count reaches zero; final pointers stay visible.
`ifndef BCS_CONSTS_SVH
`define BCS_CONSTS_SVH
`define BCS_ADDR_W      16
`define BCS_DATA_W      8
`define BCS_CNT_W       16
`define BCS_LOW_W       8
`define BCS_BASE_STATES 8
`define BCS_PER_BYTE    4
`define BCS_PRE_WAIT    3
`define BCS_POST_WAIT   3
`define BCS_PTR_STEP    16'h0001
`define BCS_CNT_STEP    16'h0001
`define BCS_CNT_ZERO    16'h0000
`define BCS_LOW_MASK    16'h00FF
`define BCS_BUF_DEPTH   2
`endif

//--- bcs_pkg.sv
// Purpose: Types for the block copy sequencer
// Assumes: Constants come from bcs_consts.svh
// Notes:   Types only
`include "bcs_consts.svh"
package bcs_pkg;
  typedef logic [`BCS_ADDR_W-1:0] bcs_addr_t;
  typedef logic [`BCS_DATA_W-1:0] bcs_data_t;
  typedef logic [`BCS_CNT_W-1:0]  bcs_cnt_t;
  typedef enum logic {
    BCS_BYTE_FORM,
    BCS_WORD_FORM
  } bcs_form_t;
endpackage : bcs_pkg

//--- bcs_buf.sv
// Purpose: Two-entry skid buffer between read data and write port
// Assumes: Single clock, synchronous active-high reset
// Notes:   Read data leaves from a register
`timescale 1ns/1ps
`default_nettype none
`include "bcs_consts.svh"
module bcs_buf (
  input  wire logic                   clk,
  input  wire logic                   rst,
  input  wire logic                   in_valid,
  output var  logic                   in_ready,
  input  wire logic [`BCS_DATA_W-1:0] in_data,
  output var  logic                   out_valid,
  input  wire logic                   out_ready,
  output var  logic [`BCS_DATA_W-1:0] out_data
);
  logic [`BCS_DATA_W-1:0] mem [`BCS_BUF_DEPTH];
  logic                   wr_ptr;
  logic                   rd_ptr;
  logic [1:0]             fill;
  logic                   push;
  logic                   pop;

  assign in_ready  = (fill != 2'h2);
  assign out_valid = (fill != 2'h0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem[rd_ptr];

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      fill   <= 2'h0;
    end else begin
      if (push) begin
        wr_ptr <= ~wr_ptr;
      end
      if (pop) begin
        rd_ptr <= ~rd_ptr;
      end
      fill <= fill + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule : bcs_buf
`default_nettype wire

//--- bcs_seq.sv
// Purpose: Sequencer for the block copy instruction
// Assumes: Memory answers a request with MEM_ACK; ack in the request cycle
//          gives 2 states per access
// Notes:   Wait states on MEM_ACK stretch the run (strobe-synchronised case)
`timescale 1ns/1ps
`default_nettype none
`include "bcs_consts.svh"
module bcs_seq
  import bcs_pkg::*;
(
  input  wire logic               MCLK,
  input  wire logic               RST,
  input  wire logic               START,
  input  wire bcs_pkg::bcs_form_t FORM,
  input  wire bcs_pkg::bcs_cnt_t  COUNT_IN,
  input  wire bcs_pkg::bcs_addr_t SRC_IN,
  input  wire bcs_pkg::bcs_addr_t DST_IN,
  output var  logic               BUSY,
  output var  logic               DONE,
  output var  bcs_pkg::bcs_cnt_t  COUNT_WORD_REG,
  output var  bcs_pkg::bcs_addr_t SOURCE_POINTER,
  output var  bcs_pkg::bcs_addr_t DEST_POINTER,
  output var  logic               MEM_REQ,
  output var  logic               MEM_WE,
  output var  bcs_pkg::bcs_addr_t MEM_ADDR,
  output var  bcs_pkg::bcs_data_t MEM_WDATA,
  input  wire bcs_pkg::bcs_data_t MEM_RDATA,
  input  wire logic               MEM_ACK
);
  import bcs_pkg::*;

  typedef enum logic [2:0] {
    BCS_IDLE,
    BCS_PRE,
    BCS_READ,
    BCS_WRITE,
    BCS_POST
  } bcs_state_t;

  bcs_state_t state;
  bcs_form_t  form;
  logic [1:0] wait_cnt;
  logic       buf_in_valid;
  logic       buf_in_ready;
  logic       buf_out_valid;
  logic       buf_out_ready;
  bcs_data_t  buf_out_data;

  function automatic logic count_done(input bcs_form_t f,
                                      input bcs_cnt_t c);
    if (f == BCS_BYTE_FORM) begin
      count_done = ((c & `BCS_LOW_MASK) == `BCS_CNT_ZERO); // [R5]
    end else begin
      count_done = (c == `BCS_CNT_ZERO); // [R2]
    end
  endfunction : count_done

  function automatic bcs_cnt_t count_next(input bcs_form_t f,
                                          input bcs_cnt_t c);
    bcs_cnt_t low;
    low = (c - `BCS_CNT_STEP) & `BCS_LOW_MASK;
    if (f == BCS_BYTE_FORM) begin
      count_next = (c & ~`BCS_LOW_MASK) | low; // [R5]
    end else begin
      count_next = c - `BCS_CNT_STEP; // [R2]
    end
  endfunction : count_next

  ////////////////////////////////////////////////////////////////////////
  // Read data staged through the buffer so a stalled write loses nothing

  // Read data go into the buffer on the acked edge itself; a staging
  // register in front of it would cost a fifth state per byte
  // One access in flight: the buffer holds one byte at most, the second
  // entry is headroom for a write that stalls on MEM_ACK
  assign buf_in_valid  = (state == BCS_READ) && MEM_REQ && MEM_ACK && !MEM_WE;
  assign buf_out_ready = (state == BCS_WRITE) && MEM_ACK && MEM_REQ;

  bcs_buf u_buf (
    .clk       (MCLK),
    .rst       (RST),
    .in_valid  (buf_in_valid),
    .in_ready  (buf_in_ready),
    .in_data   (MEM_RDATA),
    .out_valid (buf_out_valid),
    .out_ready (buf_out_ready),
    .out_data  (buf_out_data)
  );

  ////////////////////////////////////////////////////////////////////////
  // Sequencer timing with MEM_ACK high, edge 0 takes START:
  //   edges 1-3  pre wait, count tested on edge 3
  //   per byte   read request, read ack, write request, write ack
  //   4 post     edges, DONE set and BUSY cleared on the last of them
  // DONE is seen 8+4n edges after START; each MEM_ACK wait state adds
  // one edge, so a strobe-paced memory gives a variable total

  always_ff @(posedge MCLK) begin
    if (RST) begin
      state    <= BCS_IDLE;
      form     <= BCS_BYTE_FORM;
      wait_cnt <= 2'h0;
    end else begin
      case (state)
        BCS_IDLE: begin
          if (START) begin
            form     <= FORM;
            state    <= BCS_PRE;
            wait_cnt <= 2'(`BCS_PRE_WAIT - 1);
          end
        end
        BCS_PRE: begin
          if (wait_cnt != 2'h0) begin
            wait_cnt <= wait_cnt - 2'h1;
          end else if (count_done(form, COUNT_WORD_REG)) begin
            state    <= BCS_POST; // [R3]
            wait_cnt <= 2'(`BCS_POST_WAIT); // [R4]
          end else begin
            state <= BCS_READ; // [R4]
          end
        end
        BCS_READ: begin
          if (MEM_REQ && MEM_ACK) begin
            state <= BCS_WRITE; // [R6]
          end
        end
        BCS_WRITE: begin
          if (MEM_REQ && MEM_ACK) begin
            if (count_done(form, count_next(form, COUNT_WORD_REG))) begin
              state    <= BCS_POST; // [R7]
              wait_cnt <= 2'(`BCS_POST_WAIT); // [R4]
            end else begin
              state <= BCS_READ;
            end
          end
        end
        BCS_POST: begin
          if (wait_cnt != 2'h0) begin
            wait_cnt <= wait_cnt - 2'h1;
          end else begin
            state <= BCS_IDLE;
          end
        end
        default: state <= BCS_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pointer and count registers

  always_ff @(posedge MCLK) begin
    if (RST) begin
      COUNT_WORD_REG <= `BCS_CNT_ZERO;
      SOURCE_POINTER <= '0;
      DEST_POINTER   <= '0;
    end else if (state == BCS_IDLE && START) begin
      COUNT_WORD_REG <= COUNT_IN;
      SOURCE_POINTER <= SRC_IN;
      DEST_POINTER   <= DST_IN;
    end else if (buf_out_ready) begin
      SOURCE_POINTER <= SOURCE_POINTER + `BCS_PTR_STEP; // [R1]
      DEST_POINTER   <= DEST_POINTER + `BCS_PTR_STEP; // [R1]
      COUNT_WORD_REG <= count_next(form, COUNT_WORD_REG); // [R2] [R5]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Memory port, one access in flight; request held until acked

  always_ff @(posedge MCLK) begin
    if (RST) begin
      MEM_REQ   <= 1'b0;
      MEM_WE    <= 1'b0;
      MEM_ADDR  <= '0;
      MEM_WDATA <= '0;
    end else begin
      if (MEM_REQ && MEM_ACK) begin
        MEM_REQ <= 1'b0;
      end else if (!MEM_REQ && state == BCS_READ && buf_in_ready) begin
        MEM_REQ  <= 1'b1;
        MEM_WE   <= 1'b0;
        MEM_ADDR <= SOURCE_POINTER; // [R1]
      end else if (!MEM_REQ && state == BCS_WRITE && buf_out_valid) begin
        MEM_REQ   <= 1'b1;
        MEM_WE    <= 1'b1;
        MEM_ADDR  <= DEST_POINTER; // [R1]
        MEM_WDATA <= buf_out_data;
      end
    end
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      BUSY <= 1'b0;
      DONE <= 1'b0;
    end else begin
      DONE <= (state == BCS_POST) && (wait_cnt == 2'h0); // [R7]
      if (state == BCS_IDLE && START) begin
        BUSY <= 1'b1;
      end else if (state == BCS_POST && wait_cnt == 2'h0) begin
        BUSY <= 1'b0;
      end
    end
  end
endmodule : bcs_seq
`default_nettype wire

//--- bcs_seq_asserts.sv
// Purpose: Port checks for the block copy sequencer
// Assumes: One clock, RST synchronous active high
// Notes:   Bound into every bcs_seq
`timescale 1ns/1ps
`default_nettype none
module bcs_chk
  import bcs_pkg::*;
(
  input wire logic              MCLK,
  input wire logic              RST,
  input wire logic              START,
  input wire bcs_pkg::bcs_form_t FORM,
  input wire logic [15:0]       COUNT_IN,
  input wire logic              BUSY,
  input wire logic              DONE,
  input wire logic [15:0]       COUNT_WORD_REG,
  input wire logic [15:0]       SOURCE_POINTER,
  input wire logic [15:0]       DEST_POINTER,
  input wire logic              MEM_REQ,
  input wire logic              MEM_WE,
  input wire logic [15:0]       MEM_ADDR,
  input wire logic              MEM_ACK
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);
  a_rd_addr: assert property (MEM_REQ && !MEM_WE |->
    MEM_ADDR == SOURCE_POINTER) else $error("read address");
  a_wr_addr: assert property (MEM_REQ && MEM_WE |->
    MEM_ADDR == DEST_POINTER) else $error("write address");
  a_ptr_step: assert property (MEM_REQ && MEM_ACK && MEM_WE |=>
    SOURCE_POINTER == $past(SOURCE_POINTER) + 16'h0001 &&
    DEST_POINTER == $past(DEST_POINTER) + 16'h0001) else $error("step");
  a_cnt_step: assert property (MEM_REQ && MEM_ACK && MEM_WE |=>
    COUNT_WORD_REG == $past(COUNT_WORD_REG) - 16'h0001)
    else $error("count step");
  a_zero_skip: assert property (START && !BUSY &&
    (FORM == BCS_WORD_FORM ? COUNT_IN : {8'h00, COUNT_IN[7:0]}) == 16'h0000
    |=> !MEM_REQ [*7] ##1 DONE) else $error("zero count");
  a_done_end: assert property (DONE |-> !BUSY &&
    COUNT_WORD_REG[7:0] == 8'h00) else $error("done early");
  a_req_hold: assert property (MEM_REQ && !MEM_ACK |=> MEM_REQ &&
    $stable(MEM_ADDR) && $stable(MEM_WE)) else $error("wait");
  a_idle_keep: assert property (!BUSY && !START |=>
    $stable(SOURCE_POINTER) && $stable(DEST_POINTER))
    else $error("idle pointers");
  a_busy_start: assert property (START && !BUSY |=> BUSY)
    else $error("start not taken");
  c_zero: cover property (START && !BUSY && COUNT_IN == 16'h0000);
  c_write: cover property (MEM_REQ && MEM_ACK && MEM_WE);
  c_stall: cover property (MEM_REQ && !MEM_ACK);
endmodule : bcs_chk
bind bcs_seq bcs_chk u_chk (.MCLK(MCLK), .RST(RST), .START(START),
  .FORM(FORM), .COUNT_IN(COUNT_IN), .BUSY(BUSY), .DONE(DONE),
  .COUNT_WORD_REG(COUNT_WORD_REG), .SOURCE_POINTER(SOURCE_POINTER),
  .DEST_POINTER(DEST_POINTER), .MEM_REQ(MEM_REQ), .MEM_WE(MEM_WE),
  .MEM_ADDR(MEM_ADDR), .MEM_ACK(MEM_ACK));
`default_nettype wire

//--- bcs_mem.sv
// Purpose: On-chip memory model for the sequencer bus
// Assumes: Byte n preset to n[7:0]^n[15:8]^5A
// Notes:   stall holds off the acknowledge
`timescale 1ns/1ps
`default_nettype none
module bcs_mem
  import bcs_pkg::*;
(
  input  wire logic               clk,
  input  wire logic               req,
  input  wire logic               we,
  input  wire logic               stall,
  input  wire bcs_pkg::bcs_addr_t addr,
  input  wire bcs_pkg::bcs_data_t wdata,
  output var  bcs_pkg::bcs_data_t rdata,
  output var  logic               ack
);
  bcs_data_t m [0:65535];
  initial begin
    for (int i = 0; i < 65536; i++) begin
      m[i] = bcs_data_t'(i ^ (i >> 8) ^ 8'h5A);
    end
  end
  always_comb begin
    ack = req && !stall;
    // Outside a read answer the bus shows junk
    rdata = (ack && !we) ? m[addr] : ~m[addr];
  end
  always @(posedge clk) begin
    if (ack && we) begin
      m[addr] <= wdata;
    end
  end
endmodule : bcs_mem
`default_nettype wire

//--- tb_top.sv
// Purpose: Self-checking bench for bcs_seq
// Assumes: Source below 4000, destination above 8000, never read back
// Notes:   Slow runs skip the cycle count
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import bcs_pkg::*;
  logic MCLK = 0, RST = 1, START = 0, stall = 0, slow = 0;
  logic BUSY, DONE, MEM_REQ, MEM_WE, MEM_ACK;
  bcs_form_t FORM = BCS_BYTE_FORM;
  bcs_cnt_t  COUNT_IN = 16'h0000, COUNT_WORD_REG;
  bcs_addr_t SRC_IN = 16'h0000, DST_IN = 16'h0000;
  bcs_addr_t SOURCE_POINTER, DEST_POINTER, MEM_ADDR;
  bcs_data_t MEM_WDATA, MEM_RDATA;
  logic [23:0] wq[$];
  logic [47:0] dq[$];
  int tq[$];
  int err_count = 0, num_checks = 0, cyc = 0;
  bcs_seq u_dut (.MCLK(MCLK), .RST(RST), .START(START), .FORM(FORM),
    .COUNT_IN(COUNT_IN), .SRC_IN(SRC_IN), .DST_IN(DST_IN), .BUSY(BUSY),
    .DONE(DONE), .COUNT_WORD_REG(COUNT_WORD_REG),
    .SOURCE_POINTER(SOURCE_POINTER), .DEST_POINTER(DEST_POINTER),
    .MEM_REQ(MEM_REQ), .MEM_WE(MEM_WE), .MEM_ADDR(MEM_ADDR),
    .MEM_WDATA(MEM_WDATA), .MEM_RDATA(MEM_RDATA), .MEM_ACK(MEM_ACK));
  bcs_mem u_mem (.clk(MCLK), .req(MEM_REQ), .we(MEM_WE), .stall(stall),
    .addr(MEM_ADDR), .wdata(MEM_WDATA), .rdata(MEM_RDATA), .ack(MEM_ACK));
  initial forever #4 MCLK = ~MCLK;
  always @(posedge MCLK) begin
    cyc <= cyc + 1;
    stall <= slow ? 1'($urandom_range(1)) : 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////
  function automatic bcs_data_t fx(input bcs_addr_t a);
    return a[7:0] ^ a[15:8] ^ 8'h5A;
  endfunction : fx
  task automatic note(input logic ok, input string msg);
    num_checks++;
    if (ok !== 1'b1) begin
      err_count++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask : note
  task automatic chk_wr(input logic [23:0] got);
    logic [23:0] e;
    e = wq.size() ? wq.pop_front() : 'x;
    note(got === e, "write");
  endtask : chk_wr
  task automatic chk_done(input logic [47:0] got);
    logic [47:0] e;
    int t;
    e = dq.size() ? dq.pop_front() : 'x;
    t = tq.size() ? tq.pop_front() : -1;
    note(got === e && (t == 0 || t == cyc), "done");
  endtask : chk_done
  always @(posedge MCLK) begin
    if (RST === 1'b0 && (MEM_REQ && MEM_WE && MEM_ACK) === 1'b1) begin
      chk_wr({MEM_ADDR, MEM_WDATA});
    end
    if (RST === 1'b0 && DONE === 1'b1) begin
      chk_done({SOURCE_POINTER, DEST_POINTER, COUNT_WORD_REG});
    end
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic run(input bcs_form_t f, input bcs_cnt_t c, input logic s);
    bcs_addr_t sa, da;
    int n;
    sa = bcs_addr_t'($urandom) & 16'h3FFF;
    da = bcs_addr_t'($urandom) & 16'h3FFF | 16'h8000;
    n = (f == BCS_WORD_FORM) ? int'(c) : int'(c[7:0]);
    @(posedge MCLK);
    for (int i = 0; i < n; i++) begin
      wq.push_back({da + 16'(i), fx(sa + 16'(i))});
    end
    dq.push_back({sa + 16'(n), da + 16'(n),
      (f == BCS_WORD_FORM) ? 16'h0000 : {c[15:8], 8'h00}});
    tq.push_back(s ? 0 : cyc + 9 + 4 * n);
    slow <= s;
    START <= 1'b1;
    FORM <= f;
    COUNT_IN <= c;
    SRC_IN <= sa;
    DST_IN <= da;
    // Second START edge lands while busy and must be ignored
    repeat (2) @(posedge MCLK);
    START <= 1'b0;
    for (int w = 0; w < 4000 && DONE !== 1'b1; w++) begin
      @(posedge MCLK);
    end
  endtask : run
  task automatic complete_run();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : complete_run
  initial begin
    void'($urandom(97391));
    repeat (12) @(posedge MCLK);
    RST <= 1'b0;
    run(BCS_BYTE_FORM, 16'h0001, 1'b0);
    run(BCS_BYTE_FORM, 16'h1200, 1'b0);
    run(BCS_WORD_FORM, 16'h0000, 1'b0);
    run(BCS_WORD_FORM, 16'h0103, 1'b0);
    run(BCS_BYTE_FORM, 16'h34FF, 1'b0);
    repeat (8) run(bcs_form_t'($urandom_range(1)),
      bcs_cnt_t'($urandom_range(40)), 1'($urandom_range(1)));
    @(posedge MCLK);
    note(wq.size() == 0 && dq.size() == 0, "missing results");
    complete_run();
  end
  initial begin
    repeat (60000) @(posedge MCLK);
    err_count++;
    complete_run();
  end
endmodule : tb_top
`default_nettype wire
